// >>> sbs_consts.svh
// Constants of the servo-off brake sequencer
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH
`define SBS_CLK_HZ 10000000
`define SBS_TICK_MS 2
`define SBS_TICK_CYC (`SBS_CLK_HZ / 1000 * `SBS_TICK_MS)
`define SBS_SPEED_MIN 16'h001e
`define SBS_RUN_MAX 8'h64
`define SBS_REGEN_PCT 10
`define SBS_REGEN_WIN 10000
`define SBS_OFF_STALL 8'h00
`define SBS_OFF_RUN 8'h04
`define SBS_OFF_REGEN 8'h08
`define SBS_OFF_REGEN_EFF 8'h0c
`define SBS_OFF_STATUS 8'h10
`define SBS_OFF_MASK 8'h14
`define SBS_OFF_STATE 8'h18
`define SBS_DELAY_RST 8'h00
`define SBS_REGEN_RST_SMALL 2'h3
`define SBS_REGEN_RST_LARGE 2'h0
`define SBS_ST_BRAKE 0
`define SBS_ST_TRIP 1
`define SBS_ST_W 2
`define SBS_RESP_OKAY 2'h0
`define SBS_RESP_SLVERR 2'h2
`endif

// >>> sbs_pkg.sv
// Types of the servo-off brake sequencer
package sbs_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_ON, ST_STALL, ST_RUN} sbs_state_t;
endpackage

// >>> sbs_regen_mon.sv
// Regeneration duty monitor over a fixed window
`timescale 1ns/1ns
`default_nettype none
`include "sbs_consts.svh"
module sbs_regen_mon #(
    parameter int WIN_CYCLES = `SBS_REGEN_WIN,
    parameter int PCT = `SBS_REGEN_PCT
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic enable_in,
    input wire logic active_in,
    output logic over_out
);
    if (WIN_CYCLES < 10 || PCT < 1 || PCT > 99) begin : g_chk
        $error("sbs_regen_mon: bad window or ratio");
    end
    logic [31:0] win_reg, win_next, act_reg, act_next;
    logic over_reg, over_next;
    always_comb begin
        over_next = 1'b0;
        win_next = win_reg + 32'h1;
        act_next = act_reg + {31'h0, active_in};
        if (!enable_in) begin
            win_next = 32'h0;
            act_next = 32'h0;
        end else if (win_reg == 32'(WIN_CYCLES - 1)) begin
            over_next = ({32'h0, act_next} * 64'h64) > (64'(WIN_CYCLES) * 64'(PCT));
            win_next = 32'h0;
            act_next = 32'h0;
        end
    end
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            win_reg <= 32'h0;
            act_reg <= 32'h0;
            over_reg <= 1'b0;
        end else begin
            win_reg <= win_next;
            act_reg <= act_next;
            over_reg <= over_next;
        end
    end
    assign over_out = over_reg;
endmodule // sbs_regen_mon
`default_nettype wire

// >>> sbs_top.sv
// Servo-off brake sequencer with regen mode select and AXI4-Lite registers
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "sbs_consts.svh"
module sbs_top #(
    parameter int TICK_CYCLES = `SBS_TICK_CYC,
    parameter int REGEN_WIN = `SBS_REGEN_WIN,
    parameter bit SMALL_FRAME = 1'b1
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic servo_enable_input_in,
    input wire logic [15:0] motor_speed_in,
    input wire logic ctrl_power_on_in,
    input wire logic regen_switch_in,
    output logic brake_release_output_out,
    output logic motor_energize_out,
    output logic regen_enable_out,
    output logic regen_overload_trip_out,
    output logic irq_out,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    if (TICK_CYCLES < 2) begin : g_chk
        $error("sbs_top: tick period too short");
    end
    localparam logic [1:0] REGEN_RST = SMALL_FRAME ? `SBS_REGEN_RST_SMALL : `SBS_REGEN_RST_LARGE;

    // Register file and bus slave
    logic [7:0] stall_reg, stall_next, run_reg, run_next;
    logic [1:0] regen_pend_reg, regen_pend_next, regen_eff_reg, regen_eff_next;
    logic [`SBS_ST_W-1:0] mask_reg, mask_next, status_reg, status_next, w1c;
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic do_write, trip_reg, trip_next, over;
    logic [`SBS_ST_W-1:0] events;
    sbs_pkg::sbs_state_t state_reg, state_next;

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

    always_comb begin
        stall_next = stall_reg;
        run_next = run_reg;
        regen_pend_next = regen_pend_reg;
        regen_eff_next = regen_eff_reg;
        mask_next = mask_reg;
        w1c = '0;
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next = w_hold_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !s_axi_rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `SBS_RESP_OKAY;
            unique case (aw_addr_reg)
                `SBS_OFF_STALL: if (w_strb_reg[0]) stall_next = w_data_reg[7:0];
                `SBS_OFF_RUN: if (w_strb_reg[0]) begin
                    run_next = (w_data_reg[7:0] > `SBS_RUN_MAX) ? `SBS_RUN_MAX : w_data_reg[7:0];
                end
                `SBS_OFF_REGEN: if (w_strb_reg[0]) regen_pend_next = w_data_reg[1:0];
                `SBS_OFF_STATUS: if (w_strb_reg[0]) w1c = w_data_reg[`SBS_ST_W-1:0];
                `SBS_OFF_MASK: if (w_strb_reg[0]) mask_next = w_data_reg[`SBS_ST_W-1:0];
                `SBS_OFF_REGEN_EFF, `SBS_OFF_STATE: begin
                end
                default: bresp_next = `SBS_RESP_SLVERR;
            endcase
        end
        if (ctrl_power_on_in) begin
            regen_eff_next = regen_pend_reg;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = `SBS_RESP_OKAY;
            rdata_next = 32'h0;
            unique case (s_axi_araddr)
                `SBS_OFF_STALL: rdata_next[7:0] = stall_reg;
                `SBS_OFF_RUN: rdata_next[7:0] = run_reg;
                `SBS_OFF_REGEN: rdata_next[1:0] = regen_pend_reg;
                `SBS_OFF_REGEN_EFF: rdata_next[1:0] = regen_eff_reg;
                `SBS_OFF_STATUS: rdata_next[`SBS_ST_W-1:0] = status_reg;
                `SBS_OFF_MASK: rdata_next[`SBS_ST_W-1:0] = mask_reg;
                `SBS_OFF_STATE: rdata_next[5:0] = {trip_reg, 1'b0, state_reg, motor_energize_out,
                    brake_release_output_out};
                default: rresp_next = `SBS_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            stall_reg <= `SBS_DELAY_RST;
            run_reg <= `SBS_DELAY_RST;
            regen_pend_reg <= REGEN_RST;
            regen_eff_reg <= REGEN_RST;
            mask_reg <= '0;
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SBS_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= `SBS_RESP_OKAY;
            rdata_reg <= 32'h0;
        end else begin
            stall_reg <= stall_next;
            run_reg <= run_next;
            regen_pend_reg <= regen_pend_next;
            regen_eff_reg <= regen_eff_next;
            mask_reg <= mask_next;
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg <= w_hold_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // Brake sequencer
    logic [31:0] presc_reg, presc_next;
    logic [7:0] cnt_reg, cnt_next, cnt_inc;
    logic brake_reg, brake_next, energ_reg, energ_next, tick, stalled;
    assign tick = presc_reg == 32'(TICK_CYCLES - 1);
    assign cnt_inc = cnt_reg + 8'h01;
    assign stalled = motor_speed_in < `SBS_SPEED_MIN;

    always_comb begin
        state_next = state_reg;
        presc_next = tick ? 32'h0 : presc_reg + 32'h1;
        cnt_next = tick ? cnt_inc : cnt_reg;
        unique case (state_reg)
            sbs_pkg::ST_OFF: if (servo_enable_input_in) state_next = sbs_pkg::ST_ON;
            sbs_pkg::ST_ON: if (!servo_enable_input_in) begin
                if (stalled) begin
                    state_next = (stall_reg == 8'h00) ? sbs_pkg::ST_OFF : sbs_pkg::ST_STALL;
                end else begin
                    state_next = (run_reg == 8'h00) ? sbs_pkg::ST_OFF : sbs_pkg::ST_RUN;
                end
            end
            sbs_pkg::ST_STALL: if (servo_enable_input_in) begin
                state_next = sbs_pkg::ST_ON;
            end else if (tick && cnt_inc == stall_reg) begin
                state_next = sbs_pkg::ST_OFF;
            end
            sbs_pkg::ST_RUN: if (servo_enable_input_in) begin
                state_next = sbs_pkg::ST_ON;
            end else if (stalled || (tick && cnt_inc == run_reg)) begin
                state_next = sbs_pkg::ST_OFF;
            end
        endcase
        if (state_next != state_reg) begin
            presc_next = 32'h0;
            cnt_next = 8'h00;
        end
        brake_next = state_next == sbs_pkg::ST_ON || state_next == sbs_pkg::ST_RUN;
        energ_next = state_next == sbs_pkg::ST_ON || state_next == sbs_pkg::ST_STALL;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_reg <= sbs_pkg::ST_OFF;
            presc_reg <= 32'h0;
            cnt_reg <= 8'h00;
            brake_reg <= 1'b0;
            energ_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            presc_reg <= presc_next;
            cnt_reg <= cnt_next;
            brake_reg <= brake_next;
            energ_reg <= energ_next;
        end
    end
    assign brake_release_output_out = brake_reg;
    assign motor_energize_out = energ_reg;

    // Regeneration mode, overload trip and interrupts
    assign regen_enable_out = regen_eff_reg != 2'h3;
    sbs_regen_mon #(.WIN_CYCLES(REGEN_WIN), .PCT(`SBS_REGEN_PCT)) u_mon (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .enable_in(regen_enable_out),
        .active_in(regen_switch_in),
        .over_out(over)
    );
    always_comb begin
        trip_next = trip_reg || (over && regen_eff_reg <= 2'h1);
        events[`SBS_ST_BRAKE] = brake_reg && !brake_next;
        events[`SBS_ST_TRIP] = trip_next && !trip_reg;
    end
    for (genvar i = 0; i < `SBS_ST_W; i++) begin : g_st
        assign status_next[i] = events[i] || (status_reg[i] && !w1c[i]);
    end
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            trip_reg <= 1'b0;
            status_reg <= '0;
        end else begin
            trip_reg <= trip_next;
            status_reg <= status_next;
        end
    end
    assign regen_overload_trip_out = trip_reg;
    assign irq_out = |(status_reg & mask_reg);

    AST_STALL_ORDER: assert property (@(posedge clock_in) disable iff (srst_in)
        state_reg == sbs_pkg::ST_ON && !servo_enable_input_in && stalled && stall_reg != 8'h00
        |=> !brake_release_output_out && motor_energize_out)
        else $error("stall: brake not engaged before de-energize");
    AST_STALL_END: assert property (@(posedge clock_in) disable iff (srst_in)
        state_reg == sbs_pkg::ST_STALL && !servo_enable_input_in && tick && cnt_inc == stall_reg
        |=> !motor_energize_out && !brake_release_output_out)
        else $error("stall delay expiry did not de-energize");
    AST_ZERO_DELAY: assert property (@(posedge clock_in) disable iff (srst_in)
        state_reg == sbs_pkg::ST_ON && !servo_enable_input_in && !stalled && run_reg == 8'h00
        |=> !brake_release_output_out)
        else $error("zero running delay did not engage brake at once");
    AST_RUN_HOLD: assert property (@(posedge clock_in) disable iff (srst_in)
        state_reg == sbs_pkg::ST_RUN && !servo_enable_input_in && !stalled && !(tick && cnt_inc == run_reg)
        |=> brake_release_output_out && !motor_energize_out)
        else $error("running delay ended early");
    AST_RUN_MAX: assert property (@(posedge clock_in) disable iff (srst_in)
        run_reg <= `SBS_RUN_MAX)
        else $error("running delay above range");
    AST_RUN_SPEED: assert property (@(posedge clock_in) disable iff (srst_in)
        state_reg == sbs_pkg::ST_RUN && !servo_enable_input_in && stalled |=> !brake_release_output_out)
        else $error("slow speed did not engage brake");
    AST_TICK_SPAN: assert property (@(posedge clock_in) disable iff (srst_in)
        $changed(state_reg) |-> presc_reg == 32'h0 && cnt_reg == 8'h00)
        else $error("delay timer not restarted on state change");
    AST_REGEN_HOLD: assert property (@(posedge clock_in) disable iff (srst_in)
        !ctrl_power_on_in |=> $stable(regen_eff_reg))
        else $error("regen mode changed without power-up");
    AST_REGEN_LOAD: assert property (@(posedge clock_in) disable iff (srst_in)
        ctrl_power_on_in |=> regen_eff_reg == $past(regen_pend_reg))
        else $error("regen mode not adopted at power-up");
    AST_TRIP_ARM: assert property (@(posedge clock_in) disable iff (srst_in)
        over && regen_eff_reg == 2'h1 && !trip_reg |=> regen_overload_trip_out && status_reg[`SBS_ST_TRIP])
        else $error("overload did not trip");
    AST_TRIP_OFF: assert property (@(posedge clock_in) disable iff (srst_in)
        !trip_reg && regen_eff_reg >= 2'h2 |=> !regen_overload_trip_out)
        else $error("trip raised in unprotected mode");
endmodule // sbs_top
`default_nettype wire

// >>> sbs_brake_model.sv
// Behavioural model of the holding brake at the far side of the sequencer
`timescale 1ns/1ns
`default_nettype none
module sbs_brake_model #(
    parameter int ACTION_CYC = 8
) (
    input wire logic clock_in,
    input wire logic release_in,
    output logic held_out
);
    int cnt;
    initial begin
        cnt = 0;
        held_out = 1'b1;
    end
    // Brake lets go at once but grips only after its mechanical action delay
    always @(posedge clock_in) begin
        if (release_in === 1'b1) begin
            cnt <= 0;
            held_out <= 1'b0;
        end else if (cnt < ACTION_CYC) begin
            cnt <= cnt + 1;
        end else begin
            held_out <= 1'b1;
        end
    end
endmodule // sbs_brake_model
`default_nettype wire

// >>> tb.sv
// Self-checking testbench of the servo-off brake sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int T = 4;
    typedef struct {int stall; int run; int sp; int drop; int gap;} sbs_row_t;
    logic clock_in, srst_in, en, pwr, regen_sw, awv, wv, arv, held, bready, rready;
    logic brk, ener, regen_en, trip, irq, awr, wr, bv, arr, rv;
    logic [15:0] spd;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, rdat;
    logic [1:0] br, rr, rsp;
    logic [3:0] ws;
    int bad_count, checked, cycles, fb, fe;
    bit hoff;
    sbs_row_t rows[5] = '{'{3, 0, 0, 0, 12}, '{0, 0, 0, 0, 0}, '{0, 5, 100, 0, 20},
                          '{0, 0, 100, 0, 0}, '{0, 100, 100, 6, 6}};

    sbs_top #(.TICK_CYCLES(T), .REGEN_WIN(20), .SMALL_FRAME(1'b1)) uut (
        .clock_in(clock_in), .srst_in(srst_in), .servo_enable_input_in(en), .motor_speed_in(spd),
        .ctrl_power_on_in(pwr), .regen_switch_in(regen_sw), .brake_release_output_out(brk),
        .motor_energize_out(ener), .regen_enable_out(regen_en), .regen_overload_trip_out(trip),
        .irq_out(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rready));
    sbs_brake_model #(.ACTION_CYC(8)) brake (.clock_in(clock_in), .release_in(brk), .held_out(held));

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rng(input string nm, input int e, input int g);
        int lo;
        int hi;
        lo = (e == 0) ? 0 : e - T + 1;
        hi = (e == 0) ? 0 : e + 1;
        checked++;
        if (g < lo || g > hi) begin
            bad_count++;
            $display("unexpected %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ga, gw, gb, da, dw;
        int n;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        n = 0;
        da = 1'b0;
        dw = 1'b0;
        do begin
            @(negedge clock_in);
            ga = awv && awr;
            gw = wv && wr;
            gb = bv && bready;
            r = br;
            @(posedge clock_in);
            if (ga) awv <= 1'b0;
            if (gw) wv <= 1'b0;
            da = da || ga;
            dw = dw || gw;
            if (gb) bready <= 1'b0;
            else if (da && dw) bready <= 1'b1;
            n++;
        end while (!gb && n < 40);
        if (!gb) begin
            bad_count++;
            $display("unexpected write_answer expected 1 seen 0");
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ga, gr, da;
        int n;
        ara <= a;
        arv <= 1'b1;
        n = 0;
        da = 1'b0;
        do begin
            @(negedge clock_in);
            ga = arv && arr;
            gr = rv && rready;
            d = rd;
            r = rr;
            @(posedge clock_in);
            if (ga) arv <= 1'b0;
            da = da || ga;
            if (gr) rready <= 1'b0;
            else if (da) rready <= 1'b1;
            n++;
        end while (!gr && n < 40);
        if (!gr) begin
            bad_count++;
            $display("unexpected read_answer expected 1 seen 0");
        end
    endtask
    task automatic do_reset();
        srst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic pulse_power();
        pwr <= 1'b1;
        @(posedge clock_in);
        pwr <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic watch(input int drop, output int b, output int e, output bit h);
        b = -1;
        e = -1;
        h = 1'b0;
        for (int i = 1; i <= 500 && (b < 0 || e < 0); i++) begin
            @(posedge clock_in);
            if (i == drop) spd <= 16'h0000;
            @(negedge clock_in);
            if (b < 0 && brk === 1'b0) b = i;
            if (e < 0 && ener === 1'b0) begin
                e = i;
                h = held;
            end
        end
        @(posedge clock_in);
    endtask

    initial begin
        {srst_in, en, pwr, regen_sw, awv, wv, arv} = 7'h40;
        {spd, awa, ara, wd} = 64'h0;
        {bready, rready} = 2'h0;
        ws = 4'hf;
        do_reset();
        axi_rd(8'h08, rdat, rsp);
        chk("regen_pending", 32'h3, rdat);
        axi_rd(8'h0c, rdat, rsp);
        chk("regen_effective", 32'h3, rdat);
        chk("regen_enable", 32'h0, regen_en);
        axi_rd(8'h1c, rdat, rsp);
        chk("unmapped_resp", 32'h2, rsp);
        chk("unmapped_data", 32'h0, rdat);
        axi_wr(8'h04, 32'hc8, rsp);
        chk("write_resp", 32'h0, rsp);
        axi_rd(8'h04, rdat, rsp);
        chk("run_delay_clamp", 32'h64, rdat);
        axi_wr(8'h1c, 32'h1, rsp);
        chk("unmapped_wresp", 32'h2, rsp);
        ws <= 4'he;
        axi_wr(8'h00, 32'h55, rsp);
        chk("masked_wresp", 32'h0, rsp);
        ws <= 4'hf;
        axi_rd(8'h00, rdat, rsp);
        chk("masked_write_ignored", 32'h0, rdat);
        $display("test reset_map done");
        foreach (rows[i]) begin
            axi_wr(8'h00, rows[i].stall, rsp);
            axi_wr(8'h04, rows[i].run, rsp);
            spd <= rows[i].sp[15:0];
            en <= 1'b1;
            repeat (12) @(posedge clock_in);
            @(negedge clock_in);
            chk("brake_on", 32'h1, brk);
            chk("energize_on", 32'h1, ener);
            @(posedge clock_in);
            en <= 1'b0;
            watch(rows[i].drop, fb, fe, hoff);
            if (rows[i].sp < 30) begin
                rng("stall_brake_lead", 1, fb);
                rng("stall_energize_gap", rows[i].gap, fe - fb);
                if (rows[i].stall > 0) chk("brake_held_at_off", 32'h1, hoff);
            end else begin
                rng("run_energize_lead", 1, fe);
                rng("run_brake_gap", rows[i].gap, fb - fe);
            end
            $display("test row %0d done", i);
        end
        axi_rd(8'h10, rdat, rsp);
        chk("status_brake", 32'h1, rdat);
        @(negedge clock_in);
        chk("irq_masked", 32'h0, irq);
        @(posedge clock_in);
        axi_wr(8'h14, 32'h1, rsp);
        @(negedge clock_in);
        chk("irq_unmasked", 32'h1, irq);
        @(posedge clock_in);
        axi_wr(8'h10, 32'h1, rsp);
        @(negedge clock_in);
        chk("irq_cleared", 32'h0, irq);
        @(posedge clock_in);
        $display("test interrupt done");
        axi_wr(8'h08, 32'h1, rsp);
        axi_rd(8'h0c, rdat, rsp);
        chk("regen_eff_kept", 32'h3, rdat);
        pulse_power();
        axi_rd(8'h0c, rdat, rsp);
        chk("regen_eff_loaded", 32'h1, rdat);
        axi_wr(8'h14, 32'h2, rsp);
        regen_sw <= 1'b1;
        repeat (60) @(posedge clock_in);
        @(negedge clock_in);
        chk("trip_mode1", 32'h1, trip);
        chk("irq_trip", 32'h1, irq);
        chk("regen_enable_on", 32'h1, regen_en);
        @(posedge clock_in);
        regen_sw <= 1'b0;
        do_reset();
        axi_rd(8'h0c, rdat, rsp);
        chk("regen_eff_reset", 32'h3, rdat);
        axi_wr(8'h08, 32'h2, rsp);
        pulse_power();
        regen_sw <= 1'b1;
        repeat (60) @(posedge clock_in);
        @(negedge clock_in);
        chk("trip_mode2", 32'h0, trip);
        @(posedge clock_in);
        regen_sw <= 1'b0;
        axi_wr(8'h08, 32'h0, rsp);
        pulse_power();
        regen_sw <= 1'b1;
        repeat (45) @(posedge clock_in);
        @(negedge clock_in);
        chk("trip_mode0", 32'h1, trip);
        @(posedge clock_in);
        regen_sw <= 1'b0;
        $display("test regen done");
        end_sim();
    end
endmodule // tb
`default_nettype wire
